// [hdl/gbpc_pkg.sv]
// Package of constants for the generator balancing pulse control block
`default_nettype none
package gbpc_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00; // Mode and option bits
  localparam logic [7:0] FREQ_CFG_OFF = 8'h04; // Sync-range threshold, kick offset
  localparam logic [7:0] PULSE_CFG_OFF = 8'h08; // Min and max pulse ticks
  localparam logic [7:0] PAUSE_CFG_OFF = 8'h0C; // Voltage and frequency pause ticks
  localparam logic [7:0] RATE_CFG_OFF = 8'h10; // Voltage and frequency control rates
  localparam logic [7:0] QUIET_CFG_OFF = 8'h14; // Quiet time, fieldbus cycle ticks
  localparam logic [7:0] TARGET_OFF = 8'h18; // Frequency target offset
  localparam logic [7:0] STATUS_OFF = 8'h1C; // Read-only block state
  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_TEST_BIT = 0; // Test synchronization parameter
  localparam int CTRL_TAP_BIT = 1; // Voltage via tap changer
  localparam int CTRL_BUS_BIT = 2; // Commands go over fieldbus
  localparam int CTRL_ASSIGN_BIT = 3; // Switchgear assignment present
  localparam int CTRL_FNOM_LSB = 4; // Nominal frequency select, 2 bits
  localparam int HI_LSB = 16; // Upper half-word field position
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] FREQ_CFG_RST = 32'h0000_0005;
  localparam logic [31:0] PULSE_CFG_RST = 32'h03E8_0032;
  localparam logic [31:0] PAUSE_CFG_RST = 32'h03E8_03E8;
  localparam logic [31:0] RATE_CFG_RST = 32'h0001_0001;
  localparam logic [31:0] QUIET_CFG_RST = 32'h0001_00C8;
  localparam logic [31:0] TARGET_RST = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Nominal frequencies in units of 0.01 Hz
  // ----------------------------------------------------------------
  localparam logic [15:0] FNOM_50 = 16'h1388; // 50 Hz
  localparam logic [15:0] FNOM_60 = 16'h1770; // 60 Hz
  localparam logic [15:0] FNOM_16 = 16'h0686; // 16,7 Hz
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40000000; // System clock rate
  localparam int TICK_US = 1000; // Internal time tick in microseconds
  localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US; // Clocks per tick
endpackage : gbpc_pkg
`default_nettype wire

// [hdl/gbpc_chan_if.sv]
// Interface between the pulse decision logic and one pulse timer channel
`timescale 1ns/1ps
`default_nettype none
interface gbpc_chan_if;
  logic tick; // Time tick enable
  logic start; // Start a pulse now
  logic dir_in; // Requested direction, 1 = raise
  logic [15:0] dur; // Pulse length in ticks
  logic [15:0] pause; // Dead time in ticks
  logic abort; // Cut the running pulse
  logic active; // Pulse running
  logic dir; // Direction of running pulse
  logic pausing; // Dead time running
  modport ctrl (output tick, start, dir_in, dur, pause, abort, input active, dir, pausing);
  modport chan (input tick, start, dir_in, dur, pause, abort, output active, dir, pausing);
endinterface : gbpc_chan_if
`default_nettype wire

// [hdl/gbpc_pulse_chan.sv]
// One actuator pulse timer: pulse, then dead time, then idle
`timescale 1ns/1ps
`default_nettype none
module gbpc_pulse_chan (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Channel control
  gbpc_chan_if.chan ch
);
  import gbpc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CH_IDLE, CH_PULSE, CH_PAUSE} gbpc_chan_state_t;
  gbpc_chan_state_t state; // Timer phase
  logic [15:0] cnt; // Ticks left in phase
  logic dir; // Latched direction

  // Sequencer; abort does not need a tick so an inhibit acts at once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= CH_IDLE; // R23
      cnt <= 16'h0000;
      dir <= 1'b0;
    end else begin
      case (state)
        CH_IDLE: begin
          if (ch.start) begin
            state <= CH_PULSE; // R8
            cnt <= ch.dur;
            dir <= ch.dir_in;
          end
        end
        CH_PULSE: begin
          if (ch.abort) begin
            state <= CH_PAUSE; // R10
            cnt <= ch.pause;
          end else if (ch.tick) begin
            if (cnt <= 16'h0001) begin
              state <= CH_PAUSE; // R9
              cnt <= ch.pause;
            end else begin
              cnt <= cnt - 16'h0001;
            end
          end
        end
        default: begin
          // Dead time: no new pulse until it runs out
          if (ch.tick) begin
            if (cnt <= 16'h0001) begin
              state <= CH_IDLE; // R6
            end else begin
              cnt <= cnt - 16'h0001;
            end
          end
        end
      endcase
    end
  end

  assign ch.active = (state == CH_PULSE);
  assign ch.pausing = (state == CH_PAUSE);
  assign ch.dir = dir;
endmodule : gbpc_pulse_chan
`default_nettype wire

// [hdl/gbpc_top.sv]
// Balancing pulse control with APB registers, switchgear handshake, test mode
// ------------------------------------------------------------------
// Functional notes
// R1: Pulses need both voltages in range
// R2: Pulses need frequencies within half to 1.5x nominal
// R3: Pulses need sync run or start-balancing input
// R4: Block input inhibits pulses immediately
// R5: In sync range only kick pulses
// R6: No pulse during pause or after closure
// R7: In sync range need time above quiet
// R8: Compute duration from deviation, then start pulse
// R9: Pulse end starts the dead timer
// R10: Sign reversal aborts; opposite pulse after dead time
// R11: Kick when conditions unmet and time long
// R12: Kick direction follows kick offset sign
// R13: Small deviations give minimum pulse length
// R14: Frequency error taken relative to target offset
// R15: Fieldbus pulses at least one bus cycle; tap changer pulses use max pulse regardless
// R16: Assigned switchgear runs from internal control
// R17: Close request raises measurement request
// R18: Enable result ends switching success or failure
// R19: Test mode keeps close relays off
// R20: Test mode by parameter or input
// R21: Duration is difference over rate, clamped
// R22: Tap changer uses fixed max pulse
// R23: Timers on fixed tick, idle at reset
// ------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module gbpc_top #(
  parameter int TICK_DIV = gbpc_pkg::TICK_CYCLES // Clocks per time tick
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurements
  input wire logic u1_in_range,
  input wire logic u2_in_range,
  input wire logic [15:0] f1_meas,
  input wire logic [15:0] f2_meas,
  input wire logic signed [15:0] volt_err,
  input wire logic signed [15:0] freq_diff,
  input wire logic [15:0] time_to_sync,
  input wire logic volt_ok,
  input wire logic angle_ok,
  // Binary inputs and sync state
  input wire logic ext_sync_run,
  input wire logic start_balance_in,
  input wire logic block_in,
  input wire logic test_sync_in,
  input wire logic close_issued,
  input wire logic close_cmd_one,
  input wire logic close_cmd_two,
  // Switchgear control handshake
  input wire logic close_request,
  input wire logic needs_sync,
  input wire logic sync_done_in,
  input wire logic sync_enable_in,
  output logic control_measure_request,
  output logic op_success,
  output logic op_fail,
  // Actuator and relay outputs
  output logic volt_raise,
  output logic volt_lower,
  output logic freq_raise,
  output logic freq_lower,
  output logic kick_active,
  output logic close_relay_one,
  output logic close_relay_two,
  output logic test_close_one,
  output logic test_close_two
);
  import gbpc_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Magnitude of a signed deviation
  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    abs16 = v[15] ? 16'(-v) : 16'(v);
  endfunction : abs16

  // Frequency inside half to one and a half nominal
  function automatic logic f_window(input logic [15:0] f, input logic [15:0] fn);
    f_window = ({1'b0, f, 1'b0} >= {2'b00, fn}) && ({1'b0, f, 1'b0} <= ({2'b00, fn} * 18'd3));
  endfunction : f_window

  // Difference over rate, capped at max, raised to min
  function automatic logic [15:0] calc_dur(input logic [15:0] mag, input logic [15:0] rate,
                                           input logic [15:0] mn, input logic [15:0] mx);
    logic [15:0] q;
    q = (rate == 16'h0000) ? mx : (mag / rate); // R21
    if (q > mx) q = mx;
    if (q < mn) q = mn; // R13
    calc_dur = q;
  endfunction : calc_dur

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl; // Mode bits
  logic [31:0] freq_cfg; // Threshold low, kick offset high
  logic [31:0] pulse_cfg; // Min low, max high
  logic [31:0] pause_cfg; // Voltage pause low, frequency pause high
  logic [31:0] rate_cfg; // Voltage rate low, frequency rate high
  logic [31:0] quiet_cfg; // Quiet time low, bus cycle high
  logic [31:0] target; // Frequency target offset
  logic [31:0] status; // Read view of state
  logic [31:0] next_prdata; // Read mux
  logic addr_ok; // Mapped address
  logic wr_en; // Write at access

  assign wr_en = psel && penable && pwrite;

  // Address decode for reads
  always_comb begin
    addr_ok = 1'b1;
    if (paddr == CTRL_OFF) next_prdata = ctrl;
    else if (paddr == FREQ_CFG_OFF) next_prdata = freq_cfg;
    else if (paddr == PULSE_CFG_OFF) next_prdata = pulse_cfg;
    else if (paddr == PAUSE_CFG_OFF) next_prdata = pause_cfg;
    else if (paddr == RATE_CFG_OFF) next_prdata = rate_cfg;
    else if (paddr == QUIET_CFG_OFF) next_prdata = quiet_cfg;
    else if (paddr == TARGET_OFF) next_prdata = target;
    else if (paddr == STATUS_OFF) next_prdata = status;
    else begin
      next_prdata = 32'h0000_0000; // Unmapped reads zero with error
      addr_ok = 1'b0;
    end
  end

  // Answer in the first access cycle; no wait states
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite) prdata <= next_prdata;
    end
  end

  // Register writes; status is read-only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= CTRL_RST;
      freq_cfg <= FREQ_CFG_RST;
      pulse_cfg <= PULSE_CFG_RST;
      pause_cfg <= PAUSE_CFG_RST;
      rate_cfg <= RATE_CFG_RST;
      quiet_cfg <= QUIET_CFG_RST;
      target <= TARGET_RST;
    end else if (wr_en) begin
      if (paddr == CTRL_OFF) ctrl <= pwdata;
      else if (paddr == FREQ_CFG_OFF) freq_cfg <= pwdata;
      else if (paddr == PULSE_CFG_OFF) pulse_cfg <= pwdata;
      else if (paddr == PAUSE_CFG_OFF) pause_cfg <= pwdata;
      else if (paddr == RATE_CFG_OFF) rate_cfg <= pwdata;
      else if (paddr == QUIET_CFG_OFF) quiet_cfg <= pwdata;
      else if (paddr == TARGET_OFF) target <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------
  logic test_mode; // Test synchronization active
  logic tap_mode; // Tap changer balancing
  logic assigned; // Switchgear assignment present
  logic [15:0] sync_range_freq_threshold; // Sync range edge
  logic signed [15:0] kick_offset; // Kick target
  logic [15:0] min_voltage_pulse_time; // Least pulse ticks
  logic [15:0] max_voltage_pulse_time; // Longest pulse ticks
  logic [15:0] min_eff; // Least pulse after bus limit
  logic [15:0] pre_close_quiet_time; // Quiet ticks before close
  logic [15:0] fnom; // Selected nominal frequency

  assign test_mode = ctrl[CTRL_TEST_BIT] || test_sync_in; // R20
  assign tap_mode = ctrl[CTRL_TAP_BIT];
  assign assigned = ctrl[CTRL_ASSIGN_BIT];
  assign sync_range_freq_threshold = freq_cfg[15:0];
  assign kick_offset = freq_cfg[HI_LSB +: 16];
  assign min_voltage_pulse_time = pulse_cfg[15:0];
  assign max_voltage_pulse_time = pulse_cfg[HI_LSB +: 16];
  assign pre_close_quiet_time = quiet_cfg[15:0];
  // Fieldbus partner must see every pulse, so no pulse length except the tap changer one is shorter than its cycle
  assign min_eff = (ctrl[CTRL_BUS_BIT] && quiet_cfg[HI_LSB +: 16] > min_voltage_pulse_time)
                   ? quiet_cfg[HI_LSB +: 16] : min_voltage_pulse_time; // R15

  // Nominal frequency select; code 3 falls back to 50 Hz
  always_comb begin
    case (ctrl[CTRL_FNOM_LSB +: 2])
      2'd1: fnom = FNOM_60;
      2'd2: fnom = FNOM_16;
      default: fnom = FNOM_50;
    endcase
  end

  // ----------------------------------------------------------------
  // Time tick divider
  // ----------------------------------------------------------------
  logic [31:0] div_cnt; // Clocks within tick
  logic tick; // One-cycle tick enable

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt <= 32'h0000_0000; // R23
      tick <= 1'b0;
    end else if (div_cnt >= 32'(TICK_DIV - 1)) begin
      div_cnt <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Switchgear handshake
  // ----------------------------------------------------------------
  // Internal control owns the run when a component is assigned
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      control_measure_request <= 1'b0;
      op_success <= 1'b0;
      op_fail <= 1'b0;
    end else begin
      op_success <= control_measure_request && sync_done_in && sync_enable_in; // R18
      op_fail <= control_measure_request && sync_done_in && !sync_enable_in; // R18
      if (control_measure_request && sync_done_in) control_measure_request <= 1'b0;
      else if (assigned && close_request && needs_sync) control_measure_request <= 1'b1; // R17
    end
  end

  // ----------------------------------------------------------------
  // Enabling logic
  // ----------------------------------------------------------------
  logic sync_run; // Run from control or external start
  logic bal_start; // Start-balancing seen
  logic close_seen; // Closure command issued
  logic run_ok; // Run or balancing start present
  logic en; // All common conditions met
  logic in_sync; // Inside synchronous range
  logic quiet_ok; // Enough time before close
  logic signed [15:0] freq_err; // Error versus target
  logic kick_go; // Kick conditions met

  assign sync_run = assigned ? control_measure_request : ext_sync_run; // R16

  // Balancing start latch, dropped when the run ends
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bal_start <= 1'b0;
      close_seen <= 1'b0;
    end else begin
      if (start_balance_in) bal_start <= 1'b1; // R3
      else if (sync_done_in) bal_start <= 1'b0;
      if (close_issued) close_seen <= 1'b1; // R6
      else if (!sync_run && !bal_start) close_seen <= 1'b0;
    end
  end

  assign run_ok = sync_run || bal_start; // R3
  // Block input is used unregistered so it cuts pulses at once
  assign en = u1_in_range && u2_in_range // R1
              && f_window(f1_meas, fnom) && f_window(f2_meas, fnom) // R2
              && run_ok && !block_in && !close_seen && !close_issued; // R4
  assign in_sync = abs16(freq_diff) < sync_range_freq_threshold; // R5
  assign quiet_ok = time_to_sync > pre_close_quiet_time; // R7
  assign freq_err = 16'(target[15:0] - freq_diff); // R14
  assign kick_go = in_sync && !(volt_ok && angle_ok) && quiet_ok; // R11

  // ----------------------------------------------------------------
  // Pulse channels
  // ----------------------------------------------------------------
  gbpc_chan_if vch (); // Voltage channel
  gbpc_chan_if fch (); // Frequency channel
  logic v_rev; // Voltage sign against pulse
  logic f_rev; // Frequency sign against pulse

  assign v_rev = vch.active && (volt_err == 16'sh0000 || (volt_err[15] == vch.dir)); // R10
  assign f_rev = fch.active && !kick_active
                 && (freq_err == 16'sh0000 || (freq_err[15] == fch.dir)); // R10

  // Voltage: no pulse in sync range, fixed length on tap changer
  assign vch.tick = tick;
  assign vch.start = en && !in_sync && volt_err != 16'sh0000; // R5
  assign vch.dir_in = !volt_err[15];
  assign vch.dur = tap_mode ? max_voltage_pulse_time // R22
                   : calc_dur(abs16(volt_err), rate_cfg[15:0], min_eff, max_voltage_pulse_time);
  assign vch.pause = pause_cfg[15:0]; // R9
  assign vch.abort = !en || in_sync || v_rev; // R10

  // Frequency: ordinary pulses outside sync range, kicks inside
  assign fch.tick = tick;
  assign fch.start = en && (in_sync ? kick_go : freq_err != 16'sh0000); // R5
  assign fch.dir_in = in_sync ? !kick_offset[15] : !freq_err[15]; // R12
  assign fch.dur = in_sync ? min_eff // R13
                   : calc_dur(abs16(freq_err), rate_cfg[HI_LSB +: 16], min_eff,
                              max_voltage_pulse_time); // R8
  assign fch.pause = pause_cfg[HI_LSB +: 16]; // R9
  assign fch.abort = !en || f_rev || (in_sync && (!kick_active || !quiet_ok)); // R7

  gbpc_pulse_chan u_vchan (
    .clk(clk),
    .rst_n(rst_n),
    .ch(vch.chan)
  );

  gbpc_pulse_chan u_fchan (
    .clk(clk),
    .rst_n(rst_n),
    .ch(fch.chan)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Actuators gated by block once more so the inhibit needs one edge only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      volt_raise <= 1'b0; // R23
      volt_lower <= 1'b0;
      freq_raise <= 1'b0;
      freq_lower <= 1'b0;
      kick_active <= 1'b0;
    end else begin
      volt_raise <= vch.active && !vch.abort && vch.dir; // R4
      volt_lower <= vch.active && !vch.abort && !vch.dir;
      freq_raise <= fch.active && !fch.abort && fch.dir;
      freq_lower <= fch.active && !fch.abort && !fch.dir;
      if (fch.start && !fch.active && !fch.pausing) kick_active <= in_sync; // R11
      else if (!fch.active) kick_active <= 1'b0;
    end
  end

  // Close relays suppressed in test mode, indications shown instead
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      close_relay_one <= 1'b0;
      close_relay_two <= 1'b0;
      test_close_one <= 1'b0;
      test_close_two <= 1'b0;
    end else begin
      close_relay_one <= close_cmd_one && !test_mode; // R19
      close_relay_two <= close_cmd_two && !test_mode; // R19
      test_close_one <= close_cmd_one && test_mode;
      test_close_two <= close_cmd_two && test_mode;
    end
  end

  assign status = {22'h00_0000, close_seen, kick_active, fch.pausing, fch.active,
                   vch.pausing, vch.active, en, in_sync, test_mode, control_measure_request};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence v_reversed_s;
    vch.active && v_rev;
  endsequence
  sequence v_dead_s;
    !vch.active ##1 !volt_raise && !volt_lower;
  endsequence

  block_inhibit_a: assert property (block_in |=> !volt_raise && !volt_lower && !freq_raise && !freq_lower) // R4
    else $error("actuator active one cycle after block");
  relay_test_a: assert property (test_mode ##1 test_mode |-> !close_relay_one && !close_relay_two) // R19
    else $error("close relay energized in test mode");
  test_ind_a: assert property (close_cmd_one && test_mode |=> test_close_one) // R19
    else $error("test close indication missing");
  no_close_start_a: assert property (close_seen |-> !vch.start && !fch.start) // R6
    else $error("pulse start after closure");
  window_start_a: assert property (vch.start |-> u1_in_range && u2_in_range && run_ok) // R1
    else $error("voltage pulse start outside enable window");
  sync_kick_only_a: assert property (fch.start && in_sync |-> kick_go && !vch.start) // R5
    else $error("ordinary pulse inside synchronous range");
  meas_request_a: assert property (assigned && close_request && needs_sync && !sync_done_in
                                   |=> control_measure_request) // R17
    else $error("measurement request not raised");
  done_result_a: assert property (control_measure_request && sync_done_in
                                  |=> (op_success ^ op_fail) ##1 !op_success && !op_fail) // R18
    else $error("switching result not single pulse");
  rev_abort_a: assert property (v_reversed_s |=> v_dead_s) // R10
    else $error("reversed voltage pulse not aborted");
endmodule : gbpc_top
`default_nettype wire

// [dv/gbpc_gen_model.sv]
// Generator voltage controller model for the balancing bench
`timescale 1ns/1ps
`default_nettype none
module gbpc_gen_model (
  // Clock
  input wire logic clk,
  // Actuators and preset
  input wire logic raise,
  input wire logic lower,
  input wire logic load,
  input wire logic signed [15:0] preset,
  // Remaining voltage error
  output logic signed [15:0] err
);
  logic raise_d; // Last raise level
  logic lower_d; // Last lower level
  // Setpoint moves one step only once a pulse has ended, like a slow controller
  always_ff @(posedge clk) begin
    raise_d <= raise;
    lower_d <= lower;
    if (load) err <= preset;
    else if (raise_d && !raise) err <= err - 16'sd1;
    else if (lower_d && !lower) err <= err + 16'sd1;
  end
endmodule : gbpc_gen_model
`default_nettype wire

// [dv/gbpc_top_test.sv]
// Self-checking bench for the balancing pulse control block
`timescale 1ns/1ps
`default_nettype none
module gbpc_top_test;
  import gbpc_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, load = 1, blk = 1, tst = 0;
  logic cmd1 = 0, creq = 0, done = 0, sb = 1, zero = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, ebit, vr, vl, mreq, ok, relay1, tclose1;
  logic signed [15:0] verr, preset = 16'sd2, fd = 0;
  int errors = 0, comparisons = 0, len = 0;
  int notes[$]; // Expected pulse lengths in ticks
  always #12.5 clk = ~clk;
  gbpc_gen_model gbpc_gen_model_inst (.clk(clk), .raise(vr), .lower(vl), .load(load),
    .preset(preset), .err(verr));
  gbpc_top #(.TICK_DIV(4)) gbpc_top_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .u1_in_range(1'b1), .u2_in_range(1'b1),
    .f1_meas(FNOM_50), .f2_meas(FNOM_50), .volt_err(verr), .freq_diff(fd),
    .time_to_sync(16'hFFFF), .volt_ok(zero), .angle_ok(zero), .ext_sync_run(zero),
    .start_balance_in(sb), .block_in(blk), .test_sync_in(tst), .close_issued(zero),
    .close_cmd_one(cmd1), .close_cmd_two(zero), .close_request(creq), .needs_sync(creq),
    .sync_done_in(done), .sync_enable_in(done), .control_measure_request(mreq),
    .op_success(ok), .op_fail(), .volt_raise(vr), .volt_lower(vl), .freq_raise(),
    .freq_lower(), .kick_active(), .close_relay_one(relay1), .close_relay_two(),
    .test_close_one(tclose1), .test_close_two());
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One APB transfer; waits for pready with a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1 && n++ < 50);
    if (n > 50) errors++; // No answer within the bound counts as a mismatch
    rd = prdata;
    ebit = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic settle();
    for (int i = 0; i < 600 && (notes.size() || len); i++) @(posedge clk);
    check("pulses left", 0, notes.size());
  endtask : settle
  task automatic give_verdict();
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // Measure every raise pulse and match it to the oldest note
  always @(posedge clk) begin
    if (vr === 1'b1) len++;
    else if (len > 0) begin
      check("pulse ticks", notes.size() ? notes.pop_front() : 0, (len + 3) / 4);
      len = 0;
    end
  end
  initial begin
    #200us;
    errors++;
    give_verdict();
  end
  initial begin
    $urandom(64620);
    fd = 16'sd50 + 16'($urandom % 100);
    repeat (4) @(posedge clk);
    check("idle raise", 0, vr);
    rst_n <= 1;
    load <= 0;
    apb(0, CTRL_OFF, 0);
    check("ctrl reset", CTRL_RST, rd);
    apb(0, 8'h40, 0);
    check("unmapped", 1, ebit);
    // Zero frequency error, short pulses and pauses
    apb(1, TARGET_OFF, {16'h0000, fd});
    apb(1, PAUSE_CFG_OFF, 32'h0002_0002);
    apb(1, PULSE_CFG_OFF, 32'h0008_0003);
    notes = {3, 3};
    blk <= 0;
    settle();
    blk <= 1;
    preset <= 16'sd4;
    load <= 1;
    @(posedge clk);
    load <= 0;
    repeat (60) @(posedge clk);
    notes = {4, 3, 3, 3};
    blk <= 0;
    settle();
    tst <= 1;
    cmd1 <= 1;
    repeat (3) @(posedge clk);
    check("relay test", 0, relay1);
    check("test close", 1, tclose1);
    tst <= 0;
    repeat (3) @(posedge clk);
    check("relay", 1, relay1);
    cmd1 <= 0;
    apb(1, CTRL_OFF, 32'h0000_0008);
    creq <= 1;
    repeat (3) @(posedge clk);
    check("meas req", 1, mreq);
    done <= 1;
    @(posedge clk);
    done <= 0;
    @(posedge clk);
    check("success", 1, ok);
    give_verdict();
  end
endmodule : gbpc_top_test
`default_nettype wire
